// [shared/failsafe_pkg.sv]
// Constants and types shared by the output fail-safe and fault control design
package failsafe_pkg;

  // ********************************************
  // Register bus
  // ********************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam logic [7:0] OFS_OUT_DATA = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SHORT_PROT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ********************************************
  // Configuration fields
  // ********************************************
  localparam int CFG_HOLD_BIT = 0;
  localparam int CFG_STATUS_LEN_LSB = 8;
  localparam int CFG_STATUS_LEN_W = 5;
  localparam int CFG_SHORT_LEN_LSB = 16;
  localparam int CFG_SHORT_LEN_W = 6;
  localparam logic [4:0] STATUS_LEN_MAX = 5'h10;
  localparam logic [5:0] SHORT_LEN_MAX = 6'h20;
  localparam logic [4:0] STATUS_LEN_RESET = 5'h00;
  localparam logic [5:0] SHORT_LEN_RESET = 6'h00;
  localparam logic CFG_HOLD_RESET = 1'b0;

  // ********************************************
  // Module status word
  // ********************************************
  localparam int STATUS_W = 16;
  localparam int ST_FIELD_LOST = 0;
  localparam int ST_MISMATCH = 1;
  localparam int ST_MOD_FAULT = 2;
  localparam int ST_COMM_LOST = 3;
  localparam int ST_GROUP_POWER_LSB = 4;
  localparam int ST_SWITCH = 15;

  // ********************************************
  // Interrupt status and mask
  // ********************************************
  localparam int IRQ_W = 5;
  localparam int IRQ_FIELD_LOSS = 0;
  localparam int IRQ_MISMATCH = 1;
  localparam int IRQ_MOD_FAULT = 2;
  localparam int IRQ_COMM_LOST = 3;
  localparam int IRQ_SHORT = 4;

  // ********************************************
  // Points and timing
  // ********************************************
  localparam int POINTS = 32;
  localparam int GROUPS = 2;
  localparam int SYNC_W = POINTS + GROUPS + 2;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned COMM_TIMEOUT_MS = 400;
  localparam int unsigned TIMEOUT_CYCLES = COMM_TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_COMM_LOST,
    MODE_FIELD_OFF
  } mode_t;

endpackage

// [rtl/pin_sync.sv]
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // First stage is read by the second stage only
  always_comb begin
    next_st = st;
    next_st.meta = asyncIn;
    next_st.stable = st.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.stable;

endmodule

// [rtl/output_failsafe_fault_control.sv]
// Fail-safe output policy and fault reporting for a 32-point discrete output module
//
// Overview of operation
// - Switch open selects drive-low policy; switch left selects retain-last-value.
// - Drive-low policy forces every output to zero when communication is lost.
// - Retain policy keeps last commanded outputs while communication lost and field powered.
// - Configured policy must equal switch; disagreement raises a policy-mismatch fault.
// - With both powers present, an internal module fault drives all outputs zero.
// - Field power loss under either policy reports a fault and turns outputs off.
// - After field power returns, outputs stay off until fresh output data arrives.
// - Without field power, point indicators show commanded values, not actual outputs.
// - Drive-low: communication loss turns outputs off within 400 ms, indicators dark.
// - Retain: communication loss holds outputs, indicators dark, until new data arrives.
// - Status word is optional, 16 bits, absent by default; length set 0 to 16.
// - Status bit 15 shows the current policy switch position.
// - Short-protection fault area is optional, 32 bits, absent by default; length 0..32.
// - One short-protection fault bit per output; bits 0-15 group one, 16-31 group two.
// - A point's protection fault stays until cause clears or point commanded off.
// - When a protection fault clears, the output returns to its prior value.
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module output_failsafe_fault_control #(
  parameter int unsigned TIMEOUT = failsafe_pkg::TIMEOUT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [failsafe_pkg::ADDR_W-1:0] adr_i,
  input wire logic [failsafe_pkg::DATA_W-1:0] dat_i,
  input wire logic [failsafe_pkg::SEL_W-1:0] sel_i,
  output logic [failsafe_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  input wire logic policySwitchLeft,
  input wire logic moduleFault,
  input wire logic [failsafe_pkg::GROUPS-1:0] fieldPowerOk,
  input wire logic [failsafe_pkg::POINTS-1:0] shortFault,
  output logic [failsafe_pkg::POINTS-1:0] pointOut,
  output logic [failsafe_pkg::POINTS-1:0] pointLed,
  output logic irq
);
  import failsafe_pkg::*;

  localparam logic [31:0] LAST_TICK = 32'(TIMEOUT - 1);

  typedef struct packed {
    mode_t mode;
    logic [POINTS-1:0] outData;
    logic [31:0] timer;
    logic holdSel;
    logic cfgHold;
    logic [CFG_STATUS_LEN_W-1:0] statusLen;
    logic [CFG_SHORT_LEN_W-1:0] shortLen;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic ack;
    logic [DATA_W-1:0] rdData;
    logic [POINTS-1:0] pointOut;
    logic [POINTS-1:0] pointLed;
    logic irq;
  } state_t;

  // ********************************************
  // Helper functions
  // ********************************************
  function automatic logic [DATA_W-1:0] mergeBytes(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] wr,
                                                   input logic [SEL_W-1:0] sel);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Keeps only the low len bits; a zero length hides the whole area
  function automatic logic [DATA_W-1:0] lenMask(input logic [5:0] len);
    logic [DATA_W:0] ones;
    ones = (33'h1 << len) - 33'h1;
    return ones[DATA_W-1:0];
  endfunction

  function automatic logic [5:0] clampLen(input logic [5:0] len, input logic [5:0] maxLen);
    return (len > maxLen) ? maxLen : len;
  endfunction

  // ********************************************
  // Pin synchronisation
  // ********************************************
  logic [SYNC_W-1:0] syncBus;
  logic switchSync;
  logic faultSync;
  logic [GROUPS-1:0] powerSync;
  logic [POINTS-1:0] shortSync;

  pin_sync #(
    .WIDTH(SYNC_W)
  ) pinSync (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncIn({policySwitchLeft, moduleFault, fieldPowerOk, shortFault}),
    .syncOut(syncBus)
  );

  assign {switchSync, faultSync, powerSync, shortSync} = syncBus;

  // ********************************************
  // Derived conditions
  // ********************************************
  state_t st;
  state_t next_st;
  logic access;
  logic wrStrobe;
  logic dataWrite;
  logic fieldOk;
  logic mismatch;
  logic [STATUS_W-1:0] statusWord;
  logic [POINTS-1:0] shortWord;
  logic [IRQ_W-1:0] events;
  logic [DATA_W-1:0] configWord;

  assign access = cyc_i & stb_i & ~st.ack;
  assign wrStrobe = access & we_i;
  // Any byte lane of the output data word counts as a fresh update
  assign dataWrite = wrStrobe && (adr_i == OFS_OUT_DATA) && (|sel_i);
  assign fieldOk = &powerSync;
  assign mismatch = st.holdSel != st.cfgHold;
  // A fault is reported only on a point the output data commands on
  assign shortWord = shortSync & st.outData;

  always_comb begin
    statusWord = '0;
    statusWord[ST_FIELD_LOST] = ~fieldOk;
    statusWord[ST_MISMATCH] = mismatch;
    statusWord[ST_MOD_FAULT] = faultSync;
    statusWord[ST_COMM_LOST] = st.mode == MODE_COMM_LOST;
    statusWord[ST_GROUP_POWER_LSB +: GROUPS] = powerSync;
    statusWord[ST_SWITCH] = st.holdSel;
  end

  always_comb begin
    configWord = '0;
    configWord[CFG_HOLD_BIT] = st.cfgHold;
    configWord[CFG_STATUS_LEN_LSB +: CFG_STATUS_LEN_W] = st.statusLen;
    configWord[CFG_SHORT_LEN_LSB +: CFG_SHORT_LEN_W] = st.shortLen;
  end

  always_comb begin
    events = '0;
    events[IRQ_FIELD_LOSS] = ~fieldOk;
    events[IRQ_MISMATCH] = mismatch;
    events[IRQ_MOD_FAULT] = faultSync;
    events[IRQ_COMM_LOST] = st.mode == MODE_COMM_LOST;
    events[IRQ_SHORT] = |shortWord;
  end

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    logic [DATA_W-1:0] merged;
    logic [IRQ_W-1:0] clr;
    merged = '0;
    clr = '0;
    next_st = st;
    next_st.ack = access;
    next_st.holdSel = switchSync;

    if (access && !we_i) begin
      case (adr_i)
        OFS_OUT_DATA: next_st.rdData = st.outData;
        OFS_CONFIG: next_st.rdData = configWord;
        OFS_STATUS: next_st.rdData = DATA_W'(statusWord) & lenMask(6'(st.statusLen));
        OFS_SHORT_PROT: next_st.rdData = shortWord & lenMask(st.shortLen);
        OFS_IRQ_STATUS: next_st.rdData = DATA_W'(st.irqStatus);
        OFS_IRQ_MASK: next_st.rdData = DATA_W'(st.irqMask);
        default: next_st.rdData = '0;
      endcase
    end

    if (wrStrobe) begin
      case (adr_i)
        OFS_OUT_DATA: begin
          next_st.outData = mergeBytes(st.outData, dat_i, sel_i);
        end
        OFS_CONFIG: begin
          merged = mergeBytes(configWord, dat_i, sel_i);
          next_st.cfgHold = merged[CFG_HOLD_BIT];
          next_st.statusLen = 5'(clampLen(6'(merged[CFG_STATUS_LEN_LSB +: CFG_STATUS_LEN_W]),
                                          6'(STATUS_LEN_MAX)));
          next_st.shortLen = clampLen(merged[CFG_SHORT_LEN_LSB +: CFG_SHORT_LEN_W], SHORT_LEN_MAX);
        end
        OFS_IRQ_STATUS: begin
          merged = mergeBytes('0, dat_i, sel_i);
          clr = merged[IRQ_W-1:0];
        end
        OFS_IRQ_MASK: begin
          merged = mergeBytes(DATA_W'(st.irqMask), dat_i, sel_i);
          next_st.irqMask = merged[IRQ_W-1:0];
        end
        default: begin
          merged = '0;
        end
      endcase
    end

    // Timeout restarts on every fresh data word
    if (dataWrite) begin
      next_st.timer = '0;
    end else if (st.mode == MODE_RUN && st.timer != LAST_TICK) begin
      next_st.timer = st.timer + 32'h1;
    end

    case (st.mode)
      MODE_RUN: begin
        if (st.timer == LAST_TICK && !dataWrite) begin
          next_st.mode = MODE_COMM_LOST;
        end
      end
      MODE_COMM_LOST: begin
        if (dataWrite) begin
          next_st.mode = MODE_RUN;
        end
      end
      MODE_FIELD_OFF: begin
        if (dataWrite && fieldOk) begin
          next_st.mode = MODE_RUN;
        end
      end
      default: begin
        next_st.mode = MODE_FIELD_OFF;
      end
    endcase
    if (!fieldOk) begin
      next_st.mode = MODE_FIELD_OFF;
    end

    // Outputs and indicators follow the mode being entered
    case (next_st.mode)
      MODE_RUN: begin
        // The driver recovers by itself; keeping the command restores the point
        next_st.pointOut = next_st.outData;
        next_st.pointLed = next_st.outData;
      end
      MODE_COMM_LOST: begin
        next_st.pointOut = next_st.holdSel ? st.outData : '0;
        next_st.pointLed = '0;
      end
      MODE_FIELD_OFF: begin
        next_st.pointOut = '0;
        next_st.pointLed = next_st.outData;
      end
      default: begin
        next_st.pointOut = '0;
        next_st.pointLed = '0;
      end
    endcase
    if (faultSync) begin
      next_st.pointOut = '0;
      if (next_st.mode == MODE_RUN) begin
        next_st.pointLed = '0;
      end
    end

    // A new event wins over a clear in the same cycle
    next_st.irqStatus = (st.irqStatus & ~clr) | events;
    next_st.irq = |(next_st.irqStatus & next_st.irqMask);
  end

  // ********************************************
  // State register
  // ********************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '{mode: MODE_FIELD_OFF, cfgHold: CFG_HOLD_RESET, statusLen: STATUS_LEN_RESET,
              shortLen: SHORT_LEN_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = st.rdData;
  assign ack_o = st.ack;
  assign pointOut = st.pointOut;
  assign pointLed = st.pointLed;
  assign irq = st.irq;

  // ********************************************
  // Assertions
  // ********************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  chk_policy_follow: assert property (!$stable(switchSync) |-> ##2 (st.holdSel == $past(switchSync, 2)))
    else $error("policy select does not follow the switch");

  chk_drive_low: assert property ((st.mode == MODE_COMM_LOST && !st.holdSel) |-> st.pointOut == '0)
    else $error("outputs not zero under drive-low after communication loss");

  chk_hold_last: assert property ((st.mode == MODE_COMM_LOST && st.holdSel && !$past(faultSync))
                                  |-> st.pointOut == st.outData)
    else $error("outputs not held under retain policy");

  chk_mismatch_flag: assert property ((st.holdSel != st.cfgHold) |=> st.irqStatus[IRQ_MISMATCH])
    else $error("policy mismatch not flagged");

  chk_module_fault: assert property (faultSync |=> st.pointOut == '0)
    else $error("module fault did not clear outputs");

  // Sampled reset keeps the attempt at the release edge quiet; state there is still the reset value
  chk_field_off: assert property ((!reset && !fieldOk)
                                  |=> (st.mode == MODE_FIELD_OFF && st.pointOut == '0 && st.irqStatus[IRQ_FIELD_LOSS]))
    else $error("field loss did not turn outputs off");

  chk_fresh_data: assert property ((st.mode == MODE_FIELD_OFF && !dataWrite) |=> st.pointOut == '0)
    else $error("outputs left off-state without fresh data");

  chk_led_commanded: assert property ((st.mode == MODE_FIELD_OFF) |-> st.pointLed == st.outData)
    else $error("indicators not showing commanded data");

  chk_comm_timeout: assert property ((st.mode == MODE_RUN && st.timer == LAST_TICK
                                      && !dataWrite && fieldOk) |=> (st.mode == MODE_COMM_LOST && st.pointLed == '0))
    else $error("communication timeout not taken");

  chk_timer_restart: assert property (dataWrite |=> st.timer == '0)
    else $error("timeout not restarted by output data");

  chk_short_bits: assert property ((access && !we_i && adr_i == OFS_SHORT_PROT
                                    && st.shortLen == SHORT_LEN_MAX) |=> st.rdData == $past(shortWord))
    else $error("protection fault word wrong");

  cov_comm_loss: cover property (st.mode == MODE_RUN ##1 st.mode == MODE_COMM_LOST);
  cov_field_return: cover property (st.mode == MODE_FIELD_OFF ##1 st.mode == MODE_RUN);
  cov_mismatch_irq: cover property (st.irqStatus[IRQ_MISMATCH] && st.irq);
  cov_hold_policy: cover property (st.mode == MODE_COMM_LOST && st.holdSel && st.pointOut != '0);

endmodule

// [test/controller_model.sv]
// Controller-side bus master model issuing classic Wishbone single cycles
`timescale 1ns/1ns
module controller_model (
  input wire logic sys_clk,
  input wire logic ack,
  input wire logic [failsafe_pkg::DATA_W-1:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [failsafe_pkg::ADDR_W-1:0] adr,
  output logic [failsafe_pkg::DATA_W-1:0] wdat,
  output logic [failsafe_pkg::SEL_W-1:0] sel
);
  import failsafe_pkg::*;

  initial begin
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    sel = 4'h0;
  end

  // ********************************************
  // One access; waits on ack however long it takes
  // ********************************************
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    @(posedge sys_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= wr;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge sys_clk);
    while (ack !== 1'h1) @(posedge sys_clk);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    // Released address, data and byte-select lines never keep the last value, so stale data cannot pass
    adr <= ~a;
    wdat <= ~d;
    sel <= 4'h0;
  endtask
endmodule

// [test/tb.sv]
// Self-checking testbench for the output fail-safe and fault control block
`timescale 1ns/1ns
module tb;
  import failsafe_pkg::*;
  // Short timeout keeps the run brief; the communication-loss waits derive from it
  localparam int unsigned TMO = 200;

  logic sys_clk;
  logic reset;
  logic cyc;
  logic stb;
  logic we;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wdat;
  logic [SEL_W-1:0] sel;
  logic [DATA_W-1:0] rdat;
  logic ack;
  logic policySwitchLeft;
  logic moduleFault;
  logic [GROUPS-1:0] fieldPowerOk;
  logic [POINTS-1:0] shortFault;
  logic [POINTS-1:0] pointOut;
  logic [POINTS-1:0] pointLed;
  logic irq;
  int badCount = 0;
  int testsRun = 0;

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  output_failsafe_fault_control #(.TIMEOUT(TMO)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .policySwitchLeft(policySwitchLeft),
    .moduleFault(moduleFault), .fieldPowerOk(fieldPowerOk), .shortFault(shortFault),
    .pointOut(pointOut), .pointLed(pointLed), .irq(irq)
  );

  controller_model i_ctrl (
    .sys_clk(sys_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .wdat(wdat), .sel(sel)
  );

  // ********************************************
  // Shared tasks
  // ********************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_ctrl.access(1'h1, a, d, q);
  endtask

  task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    i_ctrl.access(1'h0, a, 32'h0000_0000, q);
    check(name, q & m, e);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    badCount++;
    final_report;
  end

  // ********************************************
  // Test sequence
  // ********************************************
  initial begin
    reset = 1'h1;
    policySwitchLeft = 1'h0;
    moduleFault = 1'h0;
    fieldPowerOk = 2'h3;
    shortFault = 32'h0000_0000;
    waitCyc(2);
    reset <= 1'h0;
    waitCyc(4);
    check("pointOut after reset", pointOut, 32'h0000_0000);
    rdChk("config reset", OFS_CONFIG, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk("status absent", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk("short area absent", OFS_SHORT_PROT, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(OFS_IRQ_STATUS, 32'h0000_001F);
    rdChk("irq status cleared", OFS_IRQ_STATUS, 32'h0000_001F, 32'h0000_0000);
    rdChk("irq mask reset", OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    // Status length 16, short area length 32, drive-low configured
    wr(OFS_CONFIG, 32'h0020_1000);
    rdChk("switch right", OFS_STATUS, 32'h0000_8032, 32'h0000_0030);
    policySwitchLeft <= 1'h1;
    waitCyc(5);
    rdChk("switch left mismatch", OFS_STATUS, 32'h0000_8002, 32'h0000_8002);
    wr(OFS_CONFIG, 32'h0020_1001);
    rdChk("mismatch gone", OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
    // Retain policy through a communication loss
    wr(OFS_OUT_DATA, 32'hA5A5_0F0F);
    waitCyc(2);
    check("pointOut first data", pointOut, 32'hA5A5_0F0F);
    check("pointLed first data", pointLed, 32'hA5A5_0F0F);
    waitCyc(TMO + 10);
    check("pointOut retained", pointOut, 32'hA5A5_0F0F);
    check("pointLed dark retain", pointLed, 32'h0000_0000);
    rdChk("comm lost flag", OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    rdChk("comm lost irq", OFS_IRQ_STATUS, 32'h0000_0008, 32'h0000_0008);
    wr(OFS_OUT_DATA, 32'h0000_FFFF);
    waitCyc(2);
    check("pointOut new data", pointOut, 32'h0000_FFFF);
    // Drive-low policy: timer restarts on each write, then expires
    policySwitchLeft <= 1'h0;
    wr(OFS_CONFIG, 32'h0020_1000);
    repeat (3) begin
      waitCyc(TMO - 30);
      wr(OFS_OUT_DATA, 32'h1234_5678);
    end
    waitCyc(2);
    check("pointOut timer restarted", pointOut, 32'h1234_5678);
    waitCyc(TMO + 10);
    check("pointOut forced low", pointOut, 32'h0000_0000);
    check("pointLed dark low", pointLed, 32'h0000_0000);
    // Module fault with interrupt raise, mask and clear
    wr(OFS_OUT_DATA, 32'hFFFF_0001);
    wr(OFS_IRQ_STATUS, 32'h0000_001F);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    waitCyc(2);
    check("pointOut before fault", pointOut, 32'hFFFF_0001);
    check("irq idle", irq, 1'h0);
    moduleFault <= 1'h1;
    waitCyc(5);
    check("pointOut module fault", pointOut, 32'h0000_0000);
    check("irq module fault", irq, 1'h1);
    moduleFault <= 1'h0;
    waitCyc(5);
    check("irq sticky", irq, 1'h1);
    wr(OFS_IRQ_STATUS, 32'h0000_0004);
    waitCyc(2);
    check("irq cleared", irq, 1'h0);
    // Field power loss and return
    wr(OFS_OUT_DATA, 32'h0000_00FF);
    fieldPowerOk <= 2'h2;
    waitCyc(5);
    check("pointOut field loss", pointOut, 32'h0000_0000);
    check("pointLed field loss", pointLed, 32'h0000_00FF);
    rdChk("field lost flag", OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    rdChk("field loss irq", OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(OFS_OUT_DATA, 32'h0000_0F00);
    waitCyc(2);
    check("pointLed commanded", pointLed, 32'h0000_0F00);
    check("pointOut still off", pointOut, 32'h0000_0000);
    fieldPowerOk <= 2'h3;
    waitCyc(6);
    check("pointOut held off", pointOut, 32'h0000_0000);
    wr(OFS_OUT_DATA, 32'h0000_0F00);
    waitCyc(2);
    check("pointOut fresh data", pointOut, 32'h0000_0F00);
    // Short protection per point, both groups
    wr(OFS_OUT_DATA, 32'h0001_0001);
    shortFault <= 32'h0003_0003;
    waitCyc(5);
    rdChk("short faults", OFS_SHORT_PROT, 32'hFFFF_FFFF, 32'h0001_0001);
    check("pointOut during short", pointOut, 32'h0001_0001);
    wr(OFS_IRQ_STATUS, 32'h0000_001F);
    wr(OFS_IRQ_MASK, 32'h0000_0010);
    waitCyc(2);
    check("irq short fault", irq, 1'h1);
    wr(OFS_CONFIG, 32'h0010_1000);
    rdChk("short area 16", OFS_SHORT_PROT, 32'hFFFF_FFFF, 32'h0000_0001);
    shortFault <= 32'h0000_0000;
    waitCyc(5);
    check("pointOut restored", pointOut, 32'h0001_0001);
    rdChk("short faults clear", OFS_SHORT_PROT, 32'hFFFF_FFFF, 32'h0000_0000);
    // Oversized lengths are clamped to the widths of the two areas
    wr(OFS_CONFIG, 32'h003F_1F00);
    rdChk("lengths clamped", OFS_CONFIG, 32'hFFFF_FFFF, 32'h0020_1000);
    final_report;
  end
endmodule
